//--- design/pxc_ext_ctrl.sv
// Contract
// - Writing one to bit 15 arms the next write to change protected bits.
// - The arming bit clears itself after the next management write.
// - Reserved bits 14:11, 4 and 1 read back as zero.
// - Bits 10:6 are read-only and show the management port address.
// - Hardware or power-on reset latches the address from the LED pins.
// - Software reset leaves the latched address untouched.
// - Scrambler test bit forces the descrambler out of lock.
// - At 100 Mb/s bit 3 picks NRZ or NRZI; it resets to one.
// - Invalid-code bit clear gives standard 4B/5B; it resets to zero.
// - Test mapping is used only with invalid-code bit and transmit error.
// - Test nibbles 0000 to 0111 map to a leading zero and the nibble.
// - Test nibbles 1000 to 1111 map to the fixed invalid groups.
// - Cipher disable bit bypasses both scrambler and descrambler.
`timescale 1ns/1ps
`default_nettype none
module pxc_ext_ctrl
	import pxc_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  srst,
	input  wire logic                  sw_rst,
	input  wire pxc_mgmt_s             mgmt,
	input  wire logic                  addr4_led_pin,
	input  wire logic                  addr3_led_pin,
	input  wire logic                  addr2_led_pin,
	input  wire logic                  addr1_led_pin,
	input  wire logic                  addr0_led_pin,
	input  wire logic                  link_100,
	input  wire logic                  tx_ser_bit,
	input  wire logic [PXC_NIB_W-1:0]  tx_nibble,
	input  wire logic                  tx_er,
	output logic      [15:0]           rd_data_q,
	output logic                       rd_valid_q,
	output logic                       cw_override_q,
	output logic                       descram_unlock_q,
	output logic                       scram_bypass_q,
	output logic                       nrzi_sel_q,
	output logic                       inv_code_q,
	output logic                       tx_line_q,
	output logic      [PXC_ADDR_W-1:0] phy_addr_q,
	output logic      [PXC_CODE_W-1:0] tx_code_q
);

	logic                  hit;
	logic                  reg_wr;
	logic                  reg_rd;
	logic                  arm_wr;
	logic                  cw_en_d;
	logic                  scr_test_d;
	logic                  nrzi_d;
	logic                  inv_code_d;
	logic                  ciph_dis_d;
	logic                  tx_line_d;
	logic [PXC_ADDR_W-1:0] pin_addr;
	logic [15:0]           rd_word;
	logic [15:0]           rd_data_d;

	// Address decode of the incoming management frame.
	assign hit     = (mgmt.addr == PXC_REG_EXT_CTRL);
	assign reg_wr  = mgmt.wr && hit;
	assign reg_rd  = mgmt.rd && hit;
	assign arm_wr  = reg_wr && mgmt.wdata[PXC_BIT_CW_EN];

	// The arming bit is consumed by any write and re-armed by an arming one.
	// self clear.
	assign cw_en_d = arm_wr ? 1'b1 : (mgmt.wr ? 1'b0 : cw_override_q);

	// Writable control fields; reserved write data is dropped.
	// reserved writes ignored.
	assign scr_test_d = reg_wr ? mgmt.wdata[PXC_BIT_SCR_TEST] : descram_unlock_q;
	assign nrzi_d     = reg_wr ? mgmt.wdata[PXC_BIT_NRZI] : nrzi_sel_q;
	assign inv_code_d = reg_wr ? mgmt.wdata[PXC_BIT_INV_CODE] : inv_code_q;
	assign ciph_dis_d = reg_wr ? mgmt.wdata[PXC_BIT_CIPH_DIS] : scram_bypass_q;

	// Readback word; the arming bit itself shows its live state.
	// address readback.
	always_comb begin
		rd_word = PXC_RST_WORD;
		rd_word[PXC_BIT_CW_EN] = cw_override_q;
		rd_word[PXC_BIT_ADDR_HI:PXC_BIT_ADDR_LO] = phy_addr_q;
		rd_word[PXC_BIT_SCR_TEST] = descram_unlock_q;
		rd_word[PXC_BIT_NRZI] = nrzi_sel_q;
		rd_word[PXC_BIT_INV_CODE] = inv_code_q;
		rd_word[PXC_BIT_CIPH_DIS] = scram_bypass_q;
		rd_word = rd_word & ~PXC_RSV_MASK;
	end

	assign rd_data_d = reg_rd ? rd_word : rd_data_q;

	// Serial line coding: NRZI toggles on a one only at 100 Mb/s.
	// line coding.
	assign tx_line_d = (link_100 && nrzi_sel_q) ? (tx_line_q ^ tx_ser_bit)
	                                            : tx_ser_bit;

	// Control bits; both hardware and software reset restore the defaults.
	// unlock control.
	always_ff @(posedge mclk) begin
		if (srst || sw_rst) begin
			cw_override_q    <= PXC_RST_CW_EN;
			descram_unlock_q <= PXC_RST_SCR_TEST;
			nrzi_sel_q       <= PXC_RST_NRZI;
			inv_code_q       <= PXC_RST_INV_CODE;
			scram_bypass_q   <= PXC_RST_CIPH_DIS;
		end else begin
			cw_override_q    <= cw_en_d;
			descram_unlock_q <= scr_test_d;
			nrzi_sel_q       <= nrzi_d;
			inv_code_q       <= inv_code_d;
			scram_bypass_q   <= ciph_dis_d;
		end
	end

	// Read answer and line register.
	always_ff @(posedge mclk) begin
		if (srst) begin
			rd_data_q  <= PXC_RST_WORD;
			rd_valid_q <= 1'b0;
			tx_line_q  <= 1'b0;
		end else begin
			rd_data_q  <= rd_data_d;
			rd_valid_q <= reg_rd;
			tx_line_q  <= tx_line_d;
		end
	end

	// Strap pins gathered into the address bus.
	assign pin_addr = {addr4_led_pin, addr3_led_pin, addr2_led_pin,
	                   addr1_led_pin, addr0_led_pin};

	// Address latch is reset only by srst, never by sw_rst.
	// soft reset keeps address.
	pxc_addr_latch u_addr (
		.mclk       (mclk),
		.srst       (srst),
		.pin_addr   (pin_addr),
		.phy_addr_q (phy_addr_q)
	);

	pxc_tx_map u_map (
		.mclk        (mclk),
		.srst        (srst),
		.tx_nibble   (tx_nibble),
		.tx_er       (tx_er),
		.inv_code_en (inv_code_q),
		.tx_code_q   (tx_code_q)
	);

	property p_arm;
		@(posedge mclk) disable iff (srst || sw_rst)
		arm_wr |=> cw_override_q;
	endproperty
	a_arm: assert property (p_arm)
		else $error("arming write did not set override enable");

	property p_self_clear;
		@(posedge mclk) disable iff (srst || sw_rst)
		(cw_override_q && mgmt.wr && !arm_wr) |=> !cw_override_q;
	endproperty
	a_self_clear: assert property (p_self_clear)
		else $error("override enable survived the next write");

	property p_arm_next;
		@(posedge mclk) disable iff (srst || sw_rst)
		(arm_wr ##1 !mgmt.wr) |=> cw_override_q;
	endproperty
	a_arm_next: assert property (p_arm_next)
		else $error("arming write consumed its own override");

	property p_rsv_zero;
		@(posedge mclk) disable iff (srst)
		rd_valid_q |-> ((rd_data_q & PXC_RSV_MASK) == 16'h0000);
	endproperty
	a_rsv_zero: assert property (p_rsv_zero)
		else $error("reserved bits read nonzero");

	property p_addr_read;
		@(posedge mclk) disable iff (srst)
		reg_rd |=> (rd_data_q[PXC_BIT_ADDR_HI:PXC_BIT_ADDR_LO] ==
		            $past(phy_addr_q)) && rd_valid_q;
	endproperty
	a_addr_read: assert property (p_addr_read)
		else $error("address field not returned on read");

	property p_addr_swrst;
		@(posedge mclk) disable iff (srst)
		sw_rst |=> $stable(phy_addr_q);
	endproperty
	a_addr_swrst: assert property (p_addr_swrst)
		else $error("software reset changed the address");

	property p_unlock;
		@(posedge mclk) disable iff (srst || sw_rst)
		reg_wr |=> (descram_unlock_q == $past(mgmt.wdata[PXC_BIT_SCR_TEST]));
	endproperty
	a_unlock: assert property (p_unlock)
		else $error("scrambler test bit not applied");

	property p_nrzi;
		@(posedge mclk) disable iff (srst)
		(link_100 && nrzi_sel_q) |=> (tx_line_q == ($past(tx_line_q) ^
		                              $past(tx_ser_bit)));
	endproperty
	a_nrzi: assert property (p_nrzi)
		else $error("NRZI line did not toggle on one");

	property p_nrz_rst;
		@(posedge mclk) srst |=> nrzi_sel_q && !inv_code_q;
	endproperty
	a_nrz_rst: assert property (p_nrz_rst)
		else $error("line coding defaults wrong after reset");

	property p_bypass;
		@(posedge mclk) disable iff (srst || sw_rst)
		reg_wr |=> (scram_bypass_q == $past(mgmt.wdata[PXC_BIT_CIPH_DIS]));
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("cipher disable bit not applied");

	property p_nrz;
		@(posedge mclk) disable iff (srst)
		!(link_100 && nrzi_sel_q) |=> (tx_line_q == $past(tx_ser_bit));
	endproperty
	a_nrz: assert property (p_nrz)
		else $error("NRZ line did not follow the serial bit");

	property p_nrzi_wr;
		@(posedge mclk) disable iff (srst || sw_rst)
		reg_wr |=> (nrzi_sel_q == $past(mgmt.wdata[PXC_BIT_NRZI]));
	endproperty
	a_nrzi_wr: assert property (p_nrzi_wr)
		else $error("line coding bit not applied");

	property p_inv_wr;
		@(posedge mclk) disable iff (srst || sw_rst)
		reg_wr |=> (inv_code_q == $past(mgmt.wdata[PXC_BIT_INV_CODE]));
	endproperty
	a_inv_wr: assert property (p_inv_wr)
		else $error("invalid-code bit not applied");

	property p_rd_pulse;
		@(posedge mclk) disable iff (srst)
		!reg_rd |=> !rd_valid_q;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse)
		else $error("read answer without a read");

	property p_rd_hold;
		@(posedge mclk) disable iff (srst)
		!reg_rd |=> $stable(rd_data_q);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read word changed without a read");

	property p_read_cw;
		@(posedge mclk) disable iff (srst)
		reg_rd |=> (rd_data_q[PXC_BIT_CW_EN] == $past(cw_override_q));
	endproperty
	a_read_cw: assert property (p_read_cw)
		else $error("override enable not shown on read");

	property p_cw_hold;
		@(posedge mclk) disable iff (srst || sw_rst)
		!mgmt.wr |=> $stable(cw_override_q);
	endproperty
	a_cw_hold: assert property (p_cw_hold)
		else $error("override enable moved without a write");

	property p_ctl_hold;
		@(posedge mclk) disable iff (srst || sw_rst)
		!reg_wr |=> $stable({descram_unlock_q, scram_bypass_q,
		                     nrzi_sel_q, inv_code_q});
	endproperty
	a_ctl_hold: assert property (p_ctl_hold)
		else $error("control bits moved without a write");

	property p_swrst_dflt;
		@(posedge mclk) disable iff (srst)
		sw_rst |=> (!cw_override_q && !descram_unlock_q && !scram_bypass_q &&
		            nrzi_sel_q && !inv_code_q);
	endproperty
	a_swrst_dflt: assert property (p_swrst_dflt)
		else $error("software reset did not restore control defaults");

	property p_rst_clear;
		@(posedge mclk)
		srst |=> (!cw_override_q && !rd_valid_q &&
		          !descram_unlock_q && !scram_bypass_q);
	endproperty
	a_rst_clear: assert property (p_rst_clear)
		else $error("hardware reset left a control bit set");

endmodule
`default_nettype wire

//--- design/pxc_pkg.sv
package pxc_pkg;

	// Register address of the extended control register on the management port.
	localparam logic [4:0]  PXC_REG_EXT_CTRL = 5'h10;

	// Field positions inside the extended control word.
	localparam int          PXC_BIT_CW_EN    = 15;
	localparam int          PXC_BIT_ADDR_HI  = 10;
	localparam int          PXC_BIT_ADDR_LO  = 6;
	localparam int          PXC_BIT_SCR_TEST = 5;
	localparam int          PXC_BIT_NRZI     = 3;
	localparam int          PXC_BIT_INV_CODE = 2;
	localparam int          PXC_BIT_CIPH_DIS = 0;

	// Reserved bits 14:11, 4 and 1 always read as zero.
	localparam logic [15:0] PXC_RSV_MASK     = 16'h7812;

	// Reset values of the writable control bits, the read word and the transmit code.
	localparam logic        PXC_RST_CW_EN    = 1'b0;
	localparam logic        PXC_RST_SCR_TEST = 1'b0;
	localparam logic        PXC_RST_NRZI     = 1'b1;
	localparam logic        PXC_RST_INV_CODE = 1'b0;
	localparam logic        PXC_RST_CIPH_DIS = 1'b0;
	localparam logic [15:0] PXC_RST_WORD     = 16'h0000;
	localparam logic [4:0]  PXC_RST_CODE     = 5'h1F;

	// Widths of the address and the transmit code path.
	localparam int          PXC_ADDR_W       = 5;
	localparam int          PXC_NIB_W        = 4;
	localparam int          PXC_CODE_W       = 5;

	// Halt group sent for an errored nibble in normal translation.
	localparam logic [4:0]  PXC_CODE_HALT    = 5'h04;

	// One management frame as seen by the register bank.
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} pxc_mgmt_s;

	// Standard 4B/5B data translation of a transmit nibble.
	function automatic logic [4:0] pxc_std_code(input logic [3:0] nib);
		logic [4:0] c;
		c = 5'h1E;
		case (nib)
			4'h0: c = 5'h1E;
			4'h1: c = 5'h09;
			4'h2: c = 5'h14;
			4'h3: c = 5'h15;
			4'h4: c = 5'h0A;
			4'h5: c = 5'h0B;
			4'h6: c = 5'h0E;
			4'h7: c = 5'h0F;
			4'h8: c = 5'h12;
			4'h9: c = 5'h13;
			4'hA: c = 5'h16;
			4'hB: c = 5'h17;
			4'hC: c = 5'h1A;
			4'hD: c = 5'h1B;
			4'hE: c = 5'h1C;
			default: c = 5'h1D;
		endcase
		return c;
	endfunction

	// Test translation that produces invalid and control code groups.
	function automatic logic [4:0] pxc_test_code(input logic [3:0] nib);
		logic [4:0] c;
		c = {1'b0, nib};
		case (nib)
			4'h8: c = 5'h00;
			4'h9: c = 5'h0D;
			4'hA: c = 5'h0C;
			4'hB: c = 5'h11;
			4'hC: c = 5'h10;
			4'hD: c = 5'h19;
			4'hE: c = 5'h18;
			4'hF: c = 5'h1F;
			default: c = {1'b0, nib};
		endcase
		return c;
	endfunction

endpackage

//--- design/pxc_addr_latch.sv
`timescale 1ns/1ps
`default_nettype none
module pxc_addr_latch
	import pxc_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  srst,
	input  wire logic [PXC_ADDR_W-1:0] pin_addr,
	output logic      [PXC_ADDR_W-1:0] phy_addr_q
);

	// Address straps are caught only by hardware or power-on reset.
	// strap capture.
	always_ff @(posedge mclk) begin
		if (srst) begin
			phy_addr_q <= pin_addr;
		end
	end

	// Outside hardware reset the latched address never moves.
	property p_addr_capture;
		@(posedge mclk) srst |=> (phy_addr_q == $past(pin_addr));
	endproperty
	a_addr_capture: assert property (p_addr_capture)
		else $error("address not latched from pins at reset");

	property p_addr_hold;
		@(posedge mclk) !srst |=> $stable(phy_addr_q);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("latched address moved outside hardware reset");

endmodule
`default_nettype wire

//--- design/pxc_tx_map.sv
`timescale 1ns/1ps
`default_nettype none
module pxc_tx_map
	import pxc_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  srst,
	input  wire logic [PXC_NIB_W-1:0]  tx_nibble,
	input  wire logic                  tx_er,
	input  wire logic                  inv_code_en,
	output logic      [PXC_CODE_W-1:0] tx_code_q
);

	logic                  use_test;
	logic [PXC_CODE_W-1:0] norm_code;
	logic [PXC_CODE_W-1:0] tx_code_d;

	// Test groups replace the normal table only for errored nibbles.
	// test selection.
	assign use_test  = inv_code_en && tx_er;
	assign norm_code = tx_er ? PXC_CODE_HALT : pxc_std_code(tx_nibble);
	assign tx_code_d = use_test ? pxc_test_code(tx_nibble) : norm_code;

	// Code register feeding the serializer.
	always_ff @(posedge mclk) begin
		if (srst) begin
			tx_code_q <= PXC_RST_CODE;
		end else begin
			tx_code_q <= tx_code_d;
		end
	end

	property p_low_test;
		@(posedge mclk) disable iff (srst)
		(use_test && !tx_nibble[3]) |=> (tx_code_q == {1'b0, $past(tx_nibble)});
	endproperty
	a_low_test: assert property (p_low_test)
		else $error("low test nibble not mapped with leading zero");

	property p_high_test;
		@(posedge mclk) disable iff (srst)
		(use_test && tx_nibble == 4'h9) |=> (tx_code_q == 5'h0D);
	endproperty
	a_high_test: assert property (p_high_test)
		else $error("test nibble 1001 not mapped to 01101");

	property p_std_map;
		@(posedge mclk) disable iff (srst)
		(!inv_code_en && !tx_er) |=>
			(tx_code_q == pxc_std_code($past(tx_nibble)));
	endproperty
	a_std_map: assert property (p_std_map)
		else $error("standard translation not applied");

	property p_test_needs_er;
		@(posedge mclk) disable iff (srst)
		(inv_code_en && !tx_er && tx_nibble == 4'h0) |=> (tx_code_q == 5'h1E);
	endproperty
	a_test_needs_er: assert property (p_test_needs_er)
		else $error("test mapping used without transmit error");

endmodule
`default_nettype wire

//--- tb/pxc_sta_model.sv
`timescale 1ns/1ps
`default_nettype none
module pxc_sta_model
	import pxc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rd_valid_q,
	input  wire logic [15:0] rd_data_q,
	output var pxc_mgmt_s    mgmt
);
	logic [15:0] shadow;

	// The idle frame has both strobes low.
	initial begin
		mgmt = '0;
		shadow = 16'h0008;
	end

	// One write pulse; the data lines then show the inverse value.
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		#1;
		mgmt.wr = 1'b1;
		mgmt.addr = a;
		mgmt.wdata = (a == PXC_REG_EXT_CTRL) ? (d & ~PXC_RSV_MASK) : d;
		if (a == PXC_REG_EXT_CTRL) begin
			shadow = d & ~PXC_RSV_MASK & 16'h7FFF;
		end
		@(posedge mclk);
		#1;
		mgmt.wr = 1'b0;
		mgmt.wdata = ~mgmt.wdata;
	endtask

	// One read pulse; the answer is taken one cycle later.
	task automatic rd_reg(input logic [4:0] a, output logic [15:0] d,
		output logic ok);
		@(posedge mclk);
		#1;
		mgmt.rd = 1'b1;
		mgmt.addr = a;
		@(posedge mclk);
		#1;
		mgmt.rd = 1'b0;
		ok = rd_valid_q;
		d = rd_data_q;
	endtask

	task automatic prot_wr(input logic [4:0] a, input logic [15:0] d);
		wr_reg(PXC_REG_EXT_CTRL, shadow | 16'h8000);
		wr_reg(a, d);
	endtask
endmodule
`default_nettype wire

//--- tb/pxc_ext_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pxc_ext_ctrl_tb
	import pxc_pkg::*;
;
	localparam logic [4:0] TST [16] = '{5'h00, 5'h01, 5'h02, 5'h03,
		5'h04, 5'h05, 5'h06, 5'h07, 5'h00, 5'h0D, 5'h0C, 5'h11,
		5'h10, 5'h19, 5'h18, 5'h1F};
	localparam logic [4:0] STD [16] = '{5'h1E, 5'h09, 5'h14, 5'h15,
		5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17,
		5'h1A, 5'h1B, 5'h1C, 5'h1D};
	localparam logic [7:0] LPAT = 8'hB4;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        sw_rst = 1'b0;
	logic [4:0]  pins = 5'h15;
	logic        link_100 = 1'b1;
	logic        tx_ser_bit = 1'b0;
	logic [3:0]  tx_nibble = 4'h0;
	logic        tx_er = 1'b0;
	pxc_mgmt_s   mgmt;
	logic [15:0] rd_data_q;
	logic        rd_valid_q;
	logic        cw_override_q;
	logic        descram_unlock_q;
	logic        scram_bypass_q;
	logic        nrzi_sel_q;
	logic        inv_code_q;
	logic        tx_line_q;
	logic [4:0]  phy_addr_q;
	logic [4:0]  tx_code_q;
	logic [15:0] d;
	logic        ok;
	logic [4:0]  ce;
	int          mismatches = 0;
	int          samples_checked = 0;

	always #2.5 mclk = ~mclk;

	pxc_ext_ctrl pxc_ext_ctrl_i (.mclk(mclk), .srst(srst), .sw_rst(sw_rst),
		.mgmt(mgmt), .addr4_led_pin(pins[4]), .addr3_led_pin(pins[3]),
		.addr2_led_pin(pins[2]), .addr1_led_pin(pins[1]),
		.addr0_led_pin(pins[0]), .link_100(link_100),
		.tx_ser_bit(tx_ser_bit), .tx_nibble(tx_nibble), .tx_er(tx_er),
		.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
		.cw_override_q(cw_override_q), .descram_unlock_q(descram_unlock_q),
		.scram_bypass_q(scram_bypass_q), .nrzi_sel_q(nrzi_sel_q),
		.inv_code_q(inv_code_q), .tx_line_q(tx_line_q),
		.phy_addr_q(phy_addr_q), .tx_code_q(tx_code_q));

	pxc_sta_model pxc_sta_model_i (.mclk(mclk), .rd_valid_q(rd_valid_q),
		.rd_data_q(rd_data_q), .mgmt(mgmt));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Holds the hardware reset for six cycles with the given strap value.
	task automatic hw_reset(input logic [4:0] p);
		pins = p;
		srst = 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		srst = 1'b0;
	endtask

	// Reads the control word and compares it with the expected value.
	task automatic rd_chk(input logic [15:0] exp);
		pxc_sta_model_i.rd_reg(PXC_REG_EXT_CTRL, d, ok);
		check(16'(ok), 16'h0001);
		check(d, exp);
	endtask

	// Sends eight serial bits and follows the coded line bit by bit.
	task automatic line_run(input logic lk, input logic nz);
		logic e;
		e = tx_line_q;
		link_100 = lk;
		for (int i = 0; i < 8; i++) begin
			tx_ser_bit = LPAT[i];
			@(posedge mclk);
			#1;
			e = (lk && nz) ? (e ^ LPAT[i]) : LPAT[i];
			check(16'(tx_line_q), 16'(e));
		end
	endtask

	// Watchdog well beyond the expected run time.
	initial begin
		#20000;
		mismatches++;
		conclude();
	end

	// Main sequence.
	initial begin
		hw_reset(5'h15);
		rd_chk(16'h0548);
		$display("test reset done");
		pins = 5'h0A;
		pxc_sta_model_i.wr_reg(PXC_REG_EXT_CTRL, 16'h07ED);
		rd_chk(16'h056D);
		check(16'({descram_unlock_q, scram_bypass_q, nrzi_sel_q,
			inv_code_q}), 16'h000F);
		pxc_sta_model_i.rd_reg(5'h11, d, ok);
		check(16'(ok), 16'h0000);
		$display("test control done");
		pxc_sta_model_i.wr_reg(PXC_REG_EXT_CTRL, 16'h802D);
		check(16'(cw_override_q), 16'h0001);
		rd_chk(16'h856D);
		pxc_sta_model_i.wr_reg(5'h00, 16'h1234);
		check(16'(cw_override_q), 16'h0000);
		pxc_sta_model_i.prot_wr(5'h01, 16'h0000);
		check(16'(cw_override_q), 16'h0000);
		$display("test override done");
		@(posedge mclk);
		#1;
		sw_rst = 1'b1;
		@(posedge mclk);
		#1;
		sw_rst = 1'b0;
		rd_chk(16'h0548);
		hw_reset(5'h0A);
		rd_chk(16'h0288);
		check(16'(phy_addr_q), 16'h000A);
		$display("test resets done");
		line_run(1'b1, 1'b1);
		line_run(1'b0, 1'b1);
		pxc_sta_model_i.wr_reg(PXC_REG_EXT_CTRL, 16'h0004);
		line_run(1'b1, 1'b0);
		$display("test line done");
		for (int i = 0; i < 48; i++) begin
			if (i == 32) begin
				pxc_sta_model_i.wr_reg(PXC_REG_EXT_CTRL, 16'h0000);
			end
			tx_er = (i < 16) || (i >= 32);
			tx_nibble = 4'(i % 16);
			ce = (i < 16) ? TST[i % 16] : ((i < 32) ? STD[i % 16] : 5'h04);
			@(posedge mclk);
			#1;
			check(16'(tx_code_q), 16'(ce));
		end
		$display("test map done");
		conclude();
	end
endmodule
`default_nettype wire
